/* File: verilog/mbp_pkg.sv */
// Package with shared constants for the host bus port and power control block
package mbp_pkg;
  localparam int PIN_COUNT = 52;
  localparam int PORT_A_LO = 0;
  localparam int PORT_B_LO = 8;
  localparam int PORT_C_LO = 16;
  localparam int PORT_D_LO = 24;
  localparam int PORT_E_LO = 28;
  localparam int PORT_F_LO = 36;
  localparam int PORT_G_LO = 44;
  localparam int BYTE_W = 8;
  localparam int SYNC_DEPTH = 2;
  localparam int PDN_LIMIT_DEFAULT = 16;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [2:0] CTRL_RESET = 3'h7;
  typedef enum logic [1:0] {
    FN_MCU_IO = 2'b00,
    FN_PLD_IO = 2'b01,
    FN_ADDR_OUT = 2'b10,
    FN_SPECIAL = 2'b11
  } mbp_pin_fn_type;
  typedef enum logic [1:0] {
    IN_LATCHED = 2'b00,
    IN_TRANSPARENT = 2'b01,
    IN_REGISTERED = 2'b10
  } mbp_in_mode_type;
  typedef enum logic [0:0] {
    PDN_RUN = 1'b0,
    PDN_DOWN = 1'b1
  } mbp_pdn_state_type;
endpackage

/* File: verilog/mbp_apd_if.sv */
// Interface between the port front end and the power-down unit
`timescale 1ns/1ps
interface mbp_pdn_if;
  logic enable;
  logic activity;
  logic wake;
  logic tick;
  logic power_down;
  modport front (output enable, output activity, output wake, output tick, input power_down);
  modport unit (input enable, input activity, input wake, input tick, output power_down);
endinterface

/* File: verilog/mbp_apd.sv */
// Automatic power-down unit with host inactivity counter
`timescale 1ns/1ps
module mbp_pdn #(
  parameter int LIMIT = mbp_pkg::PDN_LIMIT_DEFAULT
) (
  input wire logic i_clk,  // Core clock
  input wire logic i_reset,  // Sync reset, active high
  input wire logic i_ce,  // Clock enable
  mbp_pdn_if.unit pdu  // Link to front end
);
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);

  mbp_pkg::mbp_pdn_state_type state_q, state_d;
  logic [CW-1:0] count_q, count_d;

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    case (state_q)
      mbp_pkg::PDN_RUN: begin
        if (pdu.activity || !pdu.enable) begin
          count_d = '0;
        end else if (pdu.tick) begin
          // Counts only cycles with the logic clock tick high, so a clock halted low never powers down
          if (count_q == LIMIT_C - 1'b1) begin
            state_d = mbp_pkg::PDN_DOWN;
            count_d = '0;
          end else begin
            count_d = CW'(count_q + 1'b1);
          end
        end
      end
      mbp_pkg::PDN_DOWN: begin
        if (pdu.wake || pdu.activity || !pdu.enable) begin
          state_d = mbp_pkg::PDN_RUN;
        end
      end
      default: state_d = mbp_pkg::PDN_RUN;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= mbp_pkg::PDN_RUN;
      count_q <= '0;
    end else if (i_ce) begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  assign pdu.power_down = (state_q == mbp_pkg::PDN_DOWN);
endmodule  // mbp_pdn

/* File: verilog/mbp_port_top.sv */
// Host bus front end: address latch, read drive, paging, pin functions, power control
`timescale 1ns/1ps
// Functional notes
// - Eight-bit page register extends host address, feeds decode logic.
// - Page value reaches flash mapping so software can remap flash blocks.
// - Fast mode cleared: standby flagged while logic array inputs stay unchanged.
// - Blocking bits keep selected signals out of the logic array while set.
// - Power-down unit enters power-down after host inactivity.
// - Active-low reset pin resets ports, macrocells and configuration state.
// - Reset pin aborts a flash program or erase in progress; core reset clears the abort.
// - Address captured on latch enable or strobe, as configured.
// - Port driven only during read with internal block selected.
// - Lower port addresses forwarded to the logic arrays.
// - Strobe mode latches address on strobe rising edge.
// - Chip select low permits access; high disables memories.
// - Chip select falling edge wakes from power-down.
// - Logic clock drives macrocells and the power-down counter.
// - Upper byte written only when its active-low strobe asserts.
// - Non-multiplexed mode: one port carries D0-D7, another D8-D15.
// - Each of 52 pins: host I/O, logic I/O or latched address out.
// - Test port signals share one designated port under configuration.
// - Two ports show macrocell outputs, two show external selects.
// - Logic inputs selectable latched, transparent or registered.
module mbp_port_top #(
  parameter int PINS = mbp_pkg::PIN_COUNT,
  parameter int PD_LIMIT = mbp_pkg::PDN_LIMIT_DEFAULT
) (
  input wire logic i_clk,  // Core clock, 200 MHz
  input wire logic i_reset,  // Sync reset, active high
  input wire logic i_ce,  // Clock enable, freezes state when low
  input wire logic i_dev_reset_n,  // Device reset pin, active low
  input wire logic [15:0] i_ad_in,  // Shared address/data port, input side
  output logic [15:0] o_ad_out,  // Shared address/data port, output side
  output logic o_ad_oe_n,  // Port output enable, low drives
  input wire logic i_ale,  // Address latch enable
  input wire logic i_address_strobe_in,  // Address strobe
  input wire logic i_strobe_mode,  // 1: strobe host, 0: latch-enable host
  input wire logic i_muxed,  // 1: multiplexed address/data bus
  input wire logic i_bus16,  // 1: 16-bit data bus
  input wire logic [2:0] i_host_control_inputs,  // Read, write and spare, active low
  input wire logic i_cs_n,  // Chip select, active low
  input wire logic i_upper_byte_write_n,  // Upper byte write strobe
  input wire logic i_block_sel,  // Internal functional block selected
  input wire logic [15:0] i_rd_data,  // Read data from internal blocks
  output logic [15:0] o_wr_data,  // Captured write data
  output logic o_wr_lo,  // Lower byte write pulse
  output logic o_wr_hi,  // Upper byte write pulse
  input wire logic i_page_wr,  // Page register write
  input wire logic [7:0] i_page_wdata,  // Page register data
  output logic [7:0] o_page,  // Page register value
  output logic [7:0] o_flash_map_page,  // Page value for flash mapping
  input wire logic i_fast_mode,  // Fast mode bit of power_mode_reg_zero
  input wire logic i_block_addr,  // Blocks low address byte (power_mode_reg_two)
  input wire logic i_block_ctrl,  // Blocks control signals (power_mode_reg_two)
  input wire logic i_pdn_enable,  // Power-down unit enable
  input wire logic i_logic_clock_in,  // Logic clock tick, sampled
  output logic [15:0] o_pld_addr,  // Address to logic arrays
  output logic [2:0] o_pld_ctrl,  // Control signals to logic arrays
  output logic [7:0] o_pld_page,  // Page bits to logic arrays
  output logic o_pld_standby,  // Logic array in standby
  output logic o_macro_clk_en,  // Macrocell clock enable
  output logic o_macro_reset,  // Macrocell reset
  output logic o_power_down,  // Power-down mode
  output logic o_mem_enable,  // Memory blocks enabled
  input wire logic i_flash_busy,  // Flash program or erase running
  output logic o_flash_abort,  // Abort flash cycle
  input wire logic [2*PINS-1:0] i_pin_fn,  // Per-pin function code
  input wire logic [1:0] i_in_mode,  // Logic input mode
  input wire logic i_jtag_en,  // Test port enable on port E
  input wire logic [PINS-1:0] i_pin_in,  // Port pins, input side
  output logic [PINS-1:0] o_pin_out,  // Port pins, output side
  output logic [PINS-1:0] o_pin_oe_n,  // Port pin enable, low drives
  input wire logic [PINS-1:0] i_mcu_out,  // Host I/O output data
  input wire logic [PINS-1:0] i_mcu_dir,  // Host I/O direction, 1 output
  input wire logic [PINS-1:0] i_pld_out,  // Macrocell and select outputs
  input wire logic [PINS-1:0] i_pld_oe,  // Logic output enables
  input wire logic [7:0] i_jtag_out,  // Test port outputs
  input wire logic [7:0] i_jtag_oe,  // Test port output enables
  output logic [7:0] o_jtag_in,  // Test port inputs
  output logic [PINS-1:0] o_mcu_in,  // Pin values to host I/O
  output logic [PINS-1:0] o_pld_in  // Pin values to logic arrays
);
  localparam int BW = mbp_pkg::BYTE_W;
  localparam int SD = mbp_pkg::SYNC_DEPTH;

  mbp_pdn_if pdn_link ();

  // Device reset covers both core reset and the pin
  logic rst;
  assign rst = i_reset || !i_dev_reset_n;

  // Synchronisers; only the last stage feeds edge detection
  logic [SD-1:0] ale_s_q, as_s_q, cs_s_q;
  logic ale_d1_q, as_d1_q, cs_d1_q;
  logic [15:0] ad_p_q [0:SD];
  logic ale_fall, as_rise, cs_fall, addr_ev;
  always_ff @(posedge i_clk) begin
    if (rst) begin
      ale_s_q <= '0;
      as_s_q <= '0;
      cs_s_q <= '1;
      ale_d1_q <= 1'b0;
      as_d1_q <= 1'b0;
      cs_d1_q <= 1'b1;
    end else if (i_ce) begin
      ale_s_q <= {ale_s_q[SD-2:0], i_ale};
      as_s_q <= {as_s_q[SD-2:0], i_address_strobe_in};
      cs_s_q <= {cs_s_q[SD-2:0], i_cs_n};
      ale_d1_q <= ale_s_q[SD-1];
      as_d1_q <= as_s_q[SD-1];
      cs_d1_q <= cs_s_q[SD-1];
    end
  end
  // Address pipeline matches synchroniser delay so edges see the right word
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      ad_p_q[0] <= i_ad_in;
      for (int k = 1; k <= SD; k++) begin
        ad_p_q[k] <= ad_p_q[k-1];
      end
    end
  end
  assign ale_fall = !ale_s_q[SD-1] && ale_d1_q;
  assign as_rise = as_s_q[SD-1] && !as_d1_q;
  assign cs_fall = !cs_s_q[SD-1] && cs_d1_q;
  assign addr_ev = i_strobe_mode ? as_rise : ale_fall;

  // Address latch and page register
  logic [15:0] addr_q, addr_d;
  logic [7:0] page_q, page_d;
  always_comb begin
    addr_d = addr_q;
    page_d = page_q;
    if (i_strobe_mode && as_rise) begin
      addr_d = ad_p_q[SD-1];
    end else if (!i_strobe_mode && ale_fall) begin
      addr_d = ad_p_q[SD];
    end
    if (i_page_wr) begin
      page_d = i_page_wdata;
    end
  end
  always_ff @(posedge i_clk) begin
    if (rst) begin
      addr_q <= mbp_pkg::ADDR_RESET;
      page_q <= mbp_pkg::PAGE_RESET;
    end else if (i_ce) begin
      addr_q <= addr_d;
      page_q <= page_d;
    end
  end
  assign o_page = page_q;
  assign o_flash_map_page = page_q;

  // Power-down unit
  assign pdn_link.enable = i_pdn_enable;
  assign pdn_link.activity = addr_ev;
  assign pdn_link.wake = cs_fall;
  assign pdn_link.tick = i_logic_clock_in;
  mbp_pdn #(.LIMIT(PD_LIMIT)) u_pdn (
    .i_clk(i_clk),
    .i_reset(rst),
    .i_ce(i_ce),
    .pdu(pdn_link.unit)
  );
  logic pd;
  assign pd = pdn_link.power_down;
  assign o_power_down = pd;
  assign o_mem_enable = !i_cs_n && !pd;
  assign o_macro_clk_en = i_logic_clock_in;
  assign o_macro_reset = rst;

  // Logic array input bus with blocking and standby flag
  logic [15:0] pld_addr_q, pld_addr_d, addr_blk;
  logic [2:0] pld_ctrl_q, pld_ctrl_d, ctrl_blk;
  logic [7:0] pld_page_q, pld_page_d;
  logic standby_q, standby_d, in_change;
  always_comb begin
    addr_blk = addr_q;
    if (i_block_addr || pd) begin
      addr_blk[BW-1:0] = '0;
    end
    if (pd) begin
      addr_blk[15:BW] = '0;
    end
    ctrl_blk = (i_block_ctrl || pd) ? mbp_pkg::CTRL_RESET : i_host_control_inputs;
    in_change = (addr_blk != pld_addr_q) || (ctrl_blk != pld_ctrl_q)
      || (page_q != pld_page_q);
    pld_addr_d = addr_blk;
    pld_ctrl_d = ctrl_blk;
    pld_page_d = page_q;
    standby_d = !i_fast_mode && !in_change;
  end
  always_ff @(posedge i_clk) begin
    if (rst) begin
      pld_addr_q <= mbp_pkg::ADDR_RESET;
      pld_ctrl_q <= mbp_pkg::CTRL_RESET;
      pld_page_q <= mbp_pkg::PAGE_RESET;
      standby_q <= 1'b0;
    end else if (i_ce) begin
      pld_addr_q <= pld_addr_d;
      pld_ctrl_q <= pld_ctrl_d;
      pld_page_q <= pld_page_d;
      standby_q <= standby_d;
    end
  end
  assign o_pld_addr = pld_addr_q;
  assign o_pld_ctrl = pld_ctrl_q;
  assign o_pld_page = pld_page_q;
  assign o_pld_standby = standby_q;

  // Read drive and write capture
  logic rd_act, wr_act, wr_d1_q, wr_edge;
  logic [15:0] rd_q, wr_data_q, wr_data_d, bus_in;
  logic wr_lo_q, wr_hi_q, wr_lo_d, wr_hi_d, abort_q, abort_d;
  assign rd_act = !i_host_control_inputs[0] && !i_cs_n && i_block_sel && !pd;
  assign wr_act = !i_host_control_inputs[1] && !i_cs_n && i_block_sel && !pd;
  assign wr_edge = wr_act && !wr_d1_q;
  // Non-multiplexed data lands on ports F and G
  assign bus_in = i_muxed ? i_ad_in
    : {i_pin_in[mbp_pkg::PORT_G_LO +: BW], i_pin_in[mbp_pkg::PORT_F_LO +: BW]};
  always_comb begin
    wr_data_d = wr_edge ? bus_in : wr_data_q;
    wr_lo_d = wr_edge;
    wr_hi_d = wr_edge && i_bus16 && !i_upper_byte_write_n;
    abort_d = rst && i_flash_busy;
  end
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      rd_q <= i_rd_data;
    end
    if (rst) begin
      wr_d1_q <= 1'b0;
      wr_data_q <= '0;
      wr_lo_q <= 1'b0;
      wr_hi_q <= 1'b0;
    end else if (i_ce) begin
      wr_d1_q <= wr_act;
      wr_data_q <= wr_data_d;
      wr_lo_q <= wr_lo_d;
      wr_hi_q <= wr_hi_d;
    end
    // Abort must fire during a pin reset, so it bypasses the rst branch; core reset clears it, otherwise it tracks rst && i_flash_busy
    if (i_reset) begin
      abort_q <= 1'b0;
    end else if (i_ce) begin
      abort_q <= abort_d;
    end
  end
  assign o_ad_out = rd_q;
  assign o_ad_oe_n = !(rd_act && i_muxed);
  assign o_wr_data = wr_data_q;
  assign o_wr_lo = wr_lo_q;
  assign o_wr_hi = wr_hi_q;
  assign o_flash_abort = abort_q;

  // Logic input capture: latched holds while latch enable low
  logic [PINS-1:0] pin_reg_q, pin_lat_q, pin_lat_d;
  always_comb begin
    pin_lat_d = ale_s_q[SD-1] ? i_pin_in : pin_lat_q;
  end
  always_ff @(posedge i_clk) begin
    if (rst) begin
      pin_reg_q <= '0;
      pin_lat_q <= '0;
    end else if (i_ce) begin
      if (i_logic_clock_in) begin
        pin_reg_q <= i_pin_in;
      end
      pin_lat_q <= pin_lat_d;
    end
  end
  assign o_mcu_in = i_pin_in;

  // Per-pin function select
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      logic [1:0] fn;
      logic is_e, is_data, out_b, en_b;
      assign fn = i_pin_fn[2*g +: 2];
      assign is_e = (g >= mbp_pkg::PORT_E_LO) && (g < mbp_pkg::PORT_F_LO);
      assign is_data = !i_muxed && (g >= mbp_pkg::PORT_F_LO);
      always_comb begin
        out_b = 1'b0;
        en_b = 1'b0;
        if (is_e && i_jtag_en) begin
          out_b = i_jtag_out[(g - mbp_pkg::PORT_E_LO) % BW];
          en_b = i_jtag_oe[(g - mbp_pkg::PORT_E_LO) % BW];
        end else if (is_data) begin
          out_b = rd_q[g - mbp_pkg::PORT_F_LO];
          en_b = rd_act;
        end else if (fn == mbp_pkg::FN_MCU_IO) begin
          out_b = i_mcu_out[g];
          en_b = i_mcu_dir[g];
        end else if (fn == mbp_pkg::FN_PLD_IO) begin
          out_b = i_pld_out[g];
          en_b = i_pld_oe[g];
        end else if (fn == mbp_pkg::FN_ADDR_OUT) begin
          out_b = addr_q[g % 16];
          en_b = 1'b1;
        end
      end
      assign o_pin_out[g] = out_b;
      assign o_pin_oe_n[g] = !en_b;
      assign o_pld_in[g] = (i_in_mode == mbp_pkg::IN_REGISTERED) ? pin_reg_q[g]
        : (i_in_mode == mbp_pkg::IN_LATCHED) ? pin_lat_q[g] : i_pin_in[g];
    end
  endgenerate
  assign o_jtag_in = i_pin_in[mbp_pkg::PORT_E_LO +: BW];
endmodule  // mbp_port_top

/* File: bench/mbp_port_top_properties.sv */
// Concurrent checks on the host bus port top
`timescale 1ns/1ps
module mbp_port_top_properties (
  input wire logic i_clk,  // Core clock
  input wire logic i_reset,  // Sync reset
  input wire logic i_dev_reset_n,  // Reset pin
  input wire logic [15:0] i_ad_in,  // Port in
  input wire logic [15:0] o_ad_out,  // Read data out
  input wire logic o_ad_oe_n,  // Port enable
  input wire logic i_address_strobe_in,  // Strobe
  input wire logic i_strobe_mode,  // Strobe host
  input wire logic [2:0] i_host_control_inputs,  // Controls
  input wire logic i_cs_n,  // Chip select
  input wire logic i_upper_byte_write_n,  // Upper strobe
  input wire logic i_bus16,  // Wide bus
  input wire logic i_block_sel,  // Block selected
  input wire logic [15:0] i_rd_data,  // Read data in
  input wire logic o_wr_lo,  // Low write
  input wire logic o_wr_hi,  // High write
  input wire logic i_page_wr,  // Page write
  input wire logic [7:0] i_page_wdata,  // Page data
  input wire logic [7:0] o_page,  // Page value
  input wire logic [7:0] o_flash_map_page,  // Flash page
  input wire logic [15:0] o_pld_addr,  // Array address
  input wire logic i_block_addr,  // Address blocking
  input wire logic o_power_down,  // Power-down
  input wire logic o_mem_enable,  // Memory enable
  input wire logic i_flash_busy,  // Flash busy
  input wire logic o_flash_abort,  // Flash abort
  input wire logic o_macro_reset  // Macrocell reset
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  sequence s_strobe_rise;
    i_strobe_mode && !i_block_addr && !o_power_down && $rose(i_address_strobe_in)
      ##1 ($stable(i_ad_in) && i_strobe_mode && !i_block_addr && !o_power_down) [*5];
  endsequence
  sequence s_cs_fall;
    o_power_down && i_cs_n ##1 !i_cs_n;
  endsequence
  chk_read_gate: assert property (!o_ad_oe_n |-> !i_cs_n && !i_host_control_inputs[0]
    && i_block_sel && !o_power_down) else $error("Port driven outside a selected read");
  chk_read_data: assert property (!o_ad_oe_n |-> o_ad_out == $past(i_rd_data))
    else $error("Read data not the previous cycle word");
  chk_strobe_latch: assert property (s_strobe_rise |=> o_pld_addr == i_ad_in)
    else $error("Strobe rise did not latch the address");
  chk_page_load: assert property (i_page_wr && i_dev_reset_n |=>
    o_page == $past(i_page_wdata)) else $error("Page register not loaded");
  chk_flash_map: assert property (o_flash_map_page == o_page)
    else $error("Flash mapping page differs from page");
  chk_mem_gate: assert property (i_cs_n |-> !o_mem_enable)
    else $error("Memories enabled while deselected");
  chk_upper_write: assert property (o_wr_hi |-> o_wr_lo
    && !$past(i_upper_byte_write_n) && $past(i_bus16))
    else $error("Upper byte written unasked");
  chk_flash_abort: assert property (!i_dev_reset_n && i_flash_busy |-> ##[1:2] o_flash_abort)
    else $error("Reset did not abort the flash cycle");
  chk_macro_reset: assert property (!i_dev_reset_n |-> o_macro_reset)
    else $error("Macrocells not reset by the pin");
  chk_cs_wake: assert property (s_cs_fall |-> ##[1:6] !o_power_down)
    else $error("Chip select fall did not wake the device");
endmodule  // mbp_port_top_properties

bind mbp_port_top mbp_port_top_properties u_props (.i_clk, .i_reset, .i_dev_reset_n, .i_ad_in,
  .o_ad_out, .o_ad_oe_n, .i_address_strobe_in, .i_strobe_mode, .i_host_control_inputs, .i_cs_n,
  .i_upper_byte_write_n, .i_bus16, .i_block_sel, .i_rd_data, .o_wr_lo, .o_wr_hi, .i_page_wr,
  .i_page_wdata, .o_page, .o_flash_map_page, .o_pld_addr, .i_block_addr, .o_power_down,
  .o_mem_enable, .i_flash_busy, .o_flash_abort, .o_macro_reset);

/* File: bench/mbp_host_model.sv */
// Host-side bus model: address phases and bus levels
`timescale 1ns/1ps
module mbp_host_model (
  input wire logic i_clk,  // Core clock
  output logic o_ale,  // Address latch enable
  output logic o_strobe,  // Address strobe
  output logic [2:0] o_ctl,  // Read, write, spare, active low
  output logic o_cs_n,  // Chip select
  output logic o_upper_wr_n,  // Upper byte write strobe
  output logic [15:0] o_ad  // Shared port, host side
);
  initial begin
    o_ale = 1'b0;
    o_strobe = 1'b0;
    o_ctl = 3'h7;
    o_cs_n = 1'b1;
    o_upper_wr_n = 1'b1;
    o_ad = 16'h0000;
  end
  task automatic bus(input logic cs_n, input logic [2:0] ctl, input logic upper_n,
    input logic [15:0] ad);
    @(negedge i_clk);
    o_cs_n = cs_n;
    o_ctl = ctl;
    o_upper_wr_n = upper_n;
    // Released port must not keep showing the last word
    o_ad = ctl[1] ? ~o_ad : ad;
  endtask
  task automatic addr_phase(input logic strobe_host, input logic [15:0] a);
    @(negedge i_clk);
    o_ad = a;
    o_ale = !strobe_host;
    o_strobe = strobe_host;
    repeat (3) @(negedge i_clk);
    o_ale = 1'b0;
    o_strobe = 1'b0;
    repeat (6) @(negedge i_clk);
    o_ad = ~a;
  endtask
endmodule  // mbp_host_model

/* File: bench/mbp_port_top_bench.sv */
// Self-checking bench for the host bus port top
`timescale 1ns/1ps
module mbp_port_top_bench;
  localparam int LIM = 4;
  localparam int CEIL = 5000;
  logic i_clk, i_ale, i_address_strobe_in, i_cs_n, i_upper_byte_write_n;
  logic i_reset = 1'b1, i_ce = 1'b1, i_muxed = 1'b1, i_fast_mode = 1'b1, i_block_sel = 1'b1;
  logic i_dev_reset_n = 1'b0;
  logic i_strobe_mode = 1'b0, i_bus16 = 1'b0, i_page_wr = 1'b0, i_block_addr = 1'b0;
  logic i_block_ctrl = 1'b0, i_pdn_enable = 1'b0, i_logic_clock_in = 1'b0;
  logic i_flash_busy = 1'b0, i_jtag_en = 1'b0;
  logic o_ad_oe_n, o_wr_lo, o_wr_hi, o_pld_standby, o_macro_clk_en, o_macro_reset;
  logic o_power_down, o_mem_enable, o_flash_abort;
  logic [1:0] i_in_mode = mbp_pkg::IN_TRANSPARENT;
  logic [2:0] i_host_control_inputs, o_pld_ctrl;
  logic [7:0] i_page_wdata = 8'h00, i_jtag_out = 8'h3C, i_jtag_oe = 8'hFF;
  logic [7:0] o_page, o_flash_map_page, o_pld_page, o_jtag_in;
  logic [15:0] i_rd_data = 16'h1234, host_ad, i_ad_in, o_ad_out, o_wr_data, o_pld_addr;
  logic [103:0] i_pin_fn = 104'h0;
  logic [51:0] ext_pins = 52'h5_A5A5_0F0F_3C3C, i_mcu_out = 52'hA_5A5A_F0F0_C3C3;
  logic [51:0] i_mcu_dir = 52'hF_FFFF_FFFF_FFFF, i_pld_oe = 52'hF_FFFF_FFFF_FFFF;
  logic [51:0] i_pld_out = 52'h6_9696_1234_5678, i_pin_in, o_pin_out, o_pin_oe_n;
  logic [51:0] o_mcu_in, o_pld_in;
  int n_errors, check_count, cycles;
  // Wire levels resolved from the DUT's enables; host and external pins drive otherwise
  assign i_ad_in = o_ad_oe_n ? host_ad : o_ad_out;
  assign i_pin_in = (o_pin_oe_n & ext_pins) | (~o_pin_oe_n & o_pin_out);

  mbp_port_top #(.PD_LIMIT(LIM)) dut (.i_clk, .i_reset, .i_ce, .i_dev_reset_n, .i_ad_in,
    .o_ad_out, .o_ad_oe_n, .i_ale, .i_address_strobe_in, .i_strobe_mode, .i_muxed, .i_bus16,
    .i_host_control_inputs, .i_cs_n, .i_upper_byte_write_n, .i_block_sel, .i_rd_data,
    .o_wr_data, .o_wr_lo, .o_wr_hi, .i_page_wr, .i_page_wdata, .o_page, .o_flash_map_page,
    .i_fast_mode, .i_block_addr, .i_block_ctrl, .i_pdn_enable, .i_logic_clock_in, .o_pld_addr,
    .o_pld_ctrl, .o_pld_page, .o_pld_standby, .o_macro_clk_en, .o_macro_reset, .o_power_down,
    .o_mem_enable, .i_flash_busy, .o_flash_abort, .i_pin_fn, .i_in_mode, .i_jtag_en,
    .i_pin_in, .o_pin_out, .o_pin_oe_n, .i_mcu_out, .i_mcu_dir, .i_pld_out, .i_pld_oe,
    .i_jtag_out, .i_jtag_oe, .o_jtag_in, .o_mcu_in, .o_pld_in);
  mbp_host_model host (.i_clk, .o_ale(i_ale), .o_strobe(i_address_strobe_in),
    .o_ctl(i_host_control_inputs), .o_cs_n(i_cs_n), .o_upper_wr_n(i_upper_byte_write_n),
    .o_ad(host_ad));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == CEIL) begin
      n_errors = n_errors + 1;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [51:0] exp, input logic [51:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Bounded wait so a missing response cannot hang the run
  task automatic await(input string what, ref logic sig, input logic v);
    int k;
    k = 0;
    while (sig !== v && k < 40) begin
      cyc(1);
      k++;
    end
    chk(what, v, sig);
  endtask
  task automatic done(input string t);
    $display("Test %s finished", t);
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    cyc(16);
    i_reset = 1'b0;
    i_dev_reset_n = 1'b1;
    cyc(1);
    chk("page", mbp_pkg::PAGE_RESET, o_page);
    chk("pld_ctrl", mbp_pkg::CTRL_RESET, o_pld_ctrl);
    chk("power_down", 1'b0, o_power_down);
    done("reset");
    host.addr_phase(1'b0, 16'h3C5A);
    chk("ale_addr", 16'h3C5A, o_pld_addr);
    i_strobe_mode = 1'b1;
    host.addr_phase(1'b1, 16'hC3A5);
    chk("strobe_addr", 16'hC3A5, o_pld_addr);
    i_strobe_mode = 1'b0;
    done("address");
    host.bus(1'b0, 3'b110, 1'b1, 16'h0000);
    cyc(1);
    chk("rd_oe", 1'b0, o_ad_oe_n);
    chk("rd_data", 16'h1234, o_ad_out);
    chk("mem_en", 1'b1, o_mem_enable);
    i_block_sel = 1'b0;
    cyc(1);
    chk("unsel_oe", 1'b1, o_ad_oe_n);
    i_block_sel = 1'b1;
    host.bus(1'b1, 3'b110, 1'b1, 16'h0000);
    cyc(1);
    chk("cs_hi_oe", 1'b1, o_ad_oe_n);
    chk("cs_hi_mem", 1'b0, o_mem_enable);
    i_muxed = 1'b0;
    i_rd_data = 16'hB2C4;
    host.bus(1'b0, 3'b110, 1'b1, 16'h0000);
    cyc(1);
    chk("nm_lo", 8'hC4, o_pin_out[43:36]);
    chk("nm_hi", 8'hB2, o_pin_out[51:44]);
    chk("nm_oe", 16'h0000, o_pin_oe_n[51:36]);
    host.bus(1'b1, 3'b111, 1'b1, 16'h0000);
    i_muxed = 1'b1;
    done("read");
    i_bus16 = 1'b1;
    for (int k = 0; k < 2; k++) begin
      host.bus(1'b0, 3'b101, k[0], 16'h9E71 + 16'(k));
      await("wr_lo", o_wr_lo, 1'b1);
      chk("wr_hi", !k[0], o_wr_hi);
      chk("wr_data", 16'h9E71 + 16'(k), o_wr_data);
      host.bus(1'b1, 3'b111, 1'b1, 16'h0000);
    end
    done("write");
    for (int k = 0; k < 2; k++) begin
      i_page_wr = 1'b1;
      i_page_wdata = k ? 8'hFF : 8'hA5;
      cyc(1);
      i_page_wr = 1'b0;
      cyc(2);
      chk("page", i_page_wdata, o_page);
      chk("map_page", i_page_wdata, o_flash_map_page);
      chk("pld_page", i_page_wdata, o_pld_page);
    end
    done("page");
    host.bus(1'b1, 3'b110, 1'b1, 16'h0000);
    cyc(3);
    chk("ctrl", 3'h6, o_pld_ctrl);
    i_block_ctrl = 1'b1;
    i_block_addr = 1'b1;
    cyc(3);
    chk("ctrl_blk", 3'h7, o_pld_ctrl);
    chk("addr_blk", 16'hC300, o_pld_addr);
    i_block_ctrl = 1'b0;
    i_block_addr = 1'b0;
    host.bus(1'b1, 3'b111, 1'b1, 16'h0000);
    i_fast_mode = 1'b0;
    cyc(4);
    chk("standby", 1'b1, o_pld_standby);
    i_fast_mode = 1'b1;
    cyc(2);
    chk("fast", 1'b0, o_pld_standby);
    done("power modes");
    i_pdn_enable = 1'b1;
    repeat (2 * LIM + 4) begin
      i_logic_clock_in = ~i_logic_clock_in;
      cyc(1);
      chk("macro_clk", i_logic_clock_in, o_macro_clk_en);
    end
    chk("pd", 1'b1, o_power_down);
    host.bus(1'b0, 3'b110, 1'b1, 16'h0000);
    cyc(1);
    chk("pd_oe", 1'b1, o_ad_oe_n);
    await("wake", o_power_down, 1'b0);
    i_pdn_enable = 1'b0;
    host.bus(1'b1, 3'b111, 1'b1, 16'h0000);
    done("power down");
    i_flash_busy = 1'b1;
    i_dev_reset_n = 1'b0;
    cyc(1);
    chk("macro_rst", 1'b1, o_macro_reset);
    i_dev_reset_n = 1'b1;
    await("abort", o_flash_abort, 1'b1);
    chk("page_rst", mbp_pkg::PAGE_RESET, o_page);
    i_flash_busy = 1'b0;
    done("reset pin");
    cyc(1);
    chk("mcu_out", i_mcu_out, o_pin_out);
    chk("mcu_oe", 52'h0, o_pin_oe_n);
    chk("mcu_in", i_mcu_out, o_mcu_in);
    chk("pld_in", i_mcu_out, o_pld_in);
    i_in_mode = mbp_pkg::IN_LATCHED;
    cyc(1);
    chk("pld_lat", 52'h0, o_pld_in);
    i_in_mode = mbp_pkg::IN_REGISTERED;
    i_logic_clock_in = 1'b1;
    cyc(1);
    chk("pld_reg", i_mcu_out, o_pld_in);
    i_pin_fn = {52{mbp_pkg::FN_PLD_IO}};
    cyc(1);
    chk("pld_out", i_pld_out, o_pin_out);
    i_jtag_en = 1'b1;
    cyc(1);
    chk("jtag_out", i_jtag_out, o_pin_out[35:28]);
    chk("jtag_in", i_jtag_out, o_jtag_in);
    i_jtag_en = 1'b0;
    i_pin_fn = {52{mbp_pkg::FN_ADDR_OUT}};
    host.addr_phase(1'b0, 16'h5AC3);
    chk("addr_out", {4'h3, {3{16'h5AC3}}}, o_pin_out);
    chk("addr_oe", 52'h0, o_pin_oe_n);
    done("pins");
    close_out();
  end
endmodule  // mbp_port_top_bench
